// file: lin_ctrl_properties.sv
/* port checks for the sleep, wake and error block.
   bound to the block from the testbench top. */
`timescale 1ns/100ps
module lin_ctrl_properties import lin_sleep_pkg::*; (
  input wire logic clk, // clock
  input wire logic resetn, // reset, low
  input wire logic reg_wr, // write
  input wire logic [7:0] reg_idx, // index
  input wire logic [7:0] reg_wdata, // wdata
  input wire logic [7:0] reg_rdata, // rdata
  input wire logic master_mode, // mode
  input wire logic bus_activity, // activity
  input wire logic comm_error, // error
  input wire logic wake_tx_req, // wake send
  input wire logic frame_start, // start
  input wire logic frame_abort, // abort
  input wire logic sleep_out, // sleep
  input wire logic irq // irq
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);
  wire cw = reg_wr && reg_idx == CONTROL_IDX;
  wire sr = reg_idx == STATUS_IDX;
  a_irq_mirror: assert property (sr |-> reg_rdata[ST_IRQ] == irq)
    else $error("irq and status differ");
  a_active_follow: assert property (sr && $past(resetn)
    |-> reg_rdata[ST_ACTIVE] == $past(bus_activity))
    else $error("active bit wrong");
  a_wake_cause: assert property (wake_tx_req
    |-> cw && reg_wdata[CT_WAKEREQ]) else $error("stray wake send");
  a_start_cause: assert property (frame_start
    |-> cw && reg_wdata[CT_START] && master_mode)
    else $error("stray frame start");
  a_abort_cause: assert property (frame_abort |-> comm_error)
    else $error("stray abort");
  a_abort_irq: assert property (frame_abort |=> irq)
    else $error("abort without irq");
  a_irq_hold: assert property (irq && !(cw && reg_wdata[CT_CLRIRQ])
    |=> irq) else $error("irq dropped");
  a_sleep_load: assert property (cw
    |=> sleep_out == $past(reg_wdata[CT_SLEEP])) else $error("sleep bit");
  cover property (wake_tx_req);
  cover property (frame_abort);
  cover property (cw && reg_wdata[CT_CLRIRQ] && irq);
endmodule // lin_ctrl_properties

// file: lin_far_node.sv
/* far lin node: sends the wake pulse, may answer it.
   driven at rising edges; ping adds traffic. */
`timescale 1ns/100ps
module lin_far_node (
  input wire logic clk, // clock
  input wire logic wake_tx_req, // wake send
  input wire logic answer, // reply wanted
  input wire logic ping, // traffic
  output logic bus_activity = 1'b0, // activity
  output logic wake_tx_done = 1'b0 // wake sent
);
  int n = 0;
  always @(posedge clk) begin
    n <= wake_tx_req ? 8 : (n > 0 ? n - 1 : 0);
    wake_tx_done <= n == 5;
    bus_activity <= ping || n > 5 || (answer && n == 2);
  end
endmodule // lin_far_node

// file: lin_sleep_pkg.sv
/*
  constants for the lin sleep, wake-up and error control block.
  assumes a 10 mhz system clock and indirect register access by index.
*/
// Contract
// - slave sleeps when software sets sleep bit after decoding sleep frame.
// - sleep clear and bus quiet four seconds: set idle flag, interrupt.
// - wake request bit makes controller send wake-up signal on bus.
// - master: wake-up sent sets done and raises interrupt.
// - slave: no interrupt on send; no answer in 150 ms sets error, timeout.
// - detected wake-up sets wake-up and done flags, raises interrupt.
// - wake-up ends bus sleep; slave software then clears sleep bit.
// - any communication error abandons current frame, raises interrupt.
// - writing 1 to clear-error bit clears error register and error flag.
// - no new master message or wake-up while error flag set.
// - checksum change mid-transaction resets interface, loses transaction.
// - mode change mid-transaction resets interface, loses transaction.
// - data acknowledge skip suspends processing until next synch break.
// - status bit 7 reads bus activity.
// - status at index 0x09, read-only, resets zero, documented bit layout.
// - interrupt pending stays set until clear-interrupt bit is written.
// - done clears at start of transmission, sets when it finishes.
package lin_sleep_pkg;
  localparam logic [7:0] STATUS_IDX = 8'h09;
  localparam logic [7:0] CONTROL_IDX = 8'h08;
  localparam logic [7:0] ERROR_IDX = 8'h0a;
  localparam logic [7:0] STATUS_RESET = 8'h00;
  localparam int ST_ACTIVE = 7;
  localparam int ST_IDLE = 6;
  localparam int ST_ABORT = 5;
  localparam int ST_IDREQ = 4;
  localparam int ST_IRQ = 3;
  localparam int ST_ERROR = 2;
  localparam int ST_WAKE = 1;
  localparam int ST_DONE = 0;
  localparam int CT_START = 0;
  localparam int CT_WAKEREQ = 1;
  localparam int CT_CLRERR = 2;
  localparam int CT_CLRIRQ = 3;
  localparam int CT_DACK = 4;
  localparam int CT_SLEEP = 6;
  localparam int ER_WAKE_RESPONSE_TIMEOUT_FLAG = 2;
  localparam longint CLK_HZ = 10000000;
  localparam longint IDLE_TIME_MS = 4000;
  localparam longint WAKE_RESP_MS = 150;
  localparam longint IDLE_CYCLES = IDLE_TIME_MS * CLK_HZ / 1000;
  localparam longint WAKE_CYCLES = WAKE_RESP_MS * CLK_HZ / 1000;
  typedef enum logic [1:0] {S_IDLE, S_WAKE_TX, S_WAIT_RESP, S_SUSPEND} state_t;
endpackage

// file: lin_sleep_wake_error_ctrl.sv
/*
  sleep, wake-up and error control with the node status register.
  assumes a frame engine supplies bus activity, wake and error events.
*/
`timescale 1ns/100ps
module lin_sleep_wake_error_ctrl import lin_sleep_pkg::*; #(
  parameter int unsigned IDLE_CNT = 32'(IDLE_CYCLES),
  parameter int unsigned WAKE_CNT = 32'(WAKE_CYCLES)
) (
  input wire logic clk, // system clock
  input wire logic resetn, // async reset, active low
  input wire logic reg_wr, // indirect register write strobe
  input wire logic [7:0] reg_idx, // indirect register index
  input wire logic [7:0] reg_wdata, // write data
  output logic [7:0] reg_rdata, // read data
  input wire logic master_mode, // 1 master, 0 slave
  input wire logic cksum_cfg, // checksum configuration
  input wire logic bus_activity, // bus activity seen this cycle
  input wire logic wake_detect, // wake-up pulse seen on bus
  input wire logic wake_tx_done, // wake-up pulse finished sending
  input wire logic tx_start, // frame transmission starting
  input wire logic tx_done, // frame transmission finished
  input wire logic synch_break, // synch break received
  input wire logic id_received, // identifier received (slave)
  input wire logic comm_error, // error event
  input wire logic [7:0] error_code, // error bits for error event
  output logic wake_tx_req, // pulse: send wake-up signal
  output logic frame_start, // pulse: master frame start allowed
  output logic frame_abort, // pulse: abandon current frame
  output logic iface_reset, // pulse: interface reset
  output logic sleep_out, // sleep bit state
  output logic irq // interrupt request level
);
  logic [7:0] status_q, status_d;
  logic [7:0] err_q, err_d;
  logic sleep_q, mode_q, ck_q, busy_q, busy_d;
  logic [31:0] cnt_q, cnt_d;
  state_t state_q, state_d;
  wire wr_ctl = reg_wr && (reg_idx == CONTROL_IDX);
  wire clr_err = wr_ctl && reg_wdata[CT_CLRERR];
  wire clr_irq = wr_ctl && reg_wdata[CT_CLRIRQ];
  wire err_ok = !status_q[ST_ERROR];
  wire wake_go = wr_ctl && reg_wdata[CT_WAKEREQ] && err_ok
    && state_q == S_IDLE;
  wire start_go = wr_ctl && reg_wdata[CT_START] && master_mode
    && err_ok && state_q == S_IDLE;
  wire dack = wr_ctl && reg_wdata[CT_DACK] && !master_mode;
  wire cfg_chg = busy_q && (ck_q != cksum_cfg || mode_q != master_mode);
  wire resp_to = state_q == S_WAIT_RESP && cnt_q >= WAKE_CNT - 1;
  wire idle_to = state_q == S_IDLE && !sleep_q && !status_q[ST_IDLE]
    && cnt_q >= IDLE_CNT - 1;
  wire wake_end = state_q == S_WAKE_TX && wake_tx_done;
  assign reg_rdata = reg_idx == STATUS_IDX ? status_q
    : reg_idx == ERROR_IDX ? err_q
    : reg_idx == CONTROL_IDX ? {1'b0, sleep_q, 6'h00} : 8'h00;
  assign wake_tx_req = wake_go;
  assign frame_start = start_go;
  assign frame_abort = comm_error && busy_q;
  assign iface_reset = cfg_chg;
  assign sleep_out = sleep_q;
  assign irq = status_q[ST_IRQ];

  always_comb begin
    state_d = state_q;
    cnt_d = bus_activity ? 32'h0 : cnt_q + 32'h1;
    busy_d = busy_q;
    if (tx_start || start_go) busy_d = 1'b1;
    if (tx_done || comm_error || cfg_chg) busy_d = 1'b0;
    case (state_q)
      S_IDLE: begin
        if (wake_go) state_d = S_WAKE_TX;
        else if (dack) state_d = S_SUSPEND;
      end
      S_WAKE_TX: if (wake_tx_done) begin
        state_d = master_mode ? S_IDLE : S_WAIT_RESP;
        cnt_d = 32'h0;
      end
      S_WAIT_RESP: if (bus_activity || resp_to) state_d = S_IDLE;
      S_SUSPEND: if (synch_break) state_d = S_IDLE;
      default: state_d = S_IDLE;
    endcase
    if (cfg_chg) state_d = S_IDLE;
  end

  always_comb begin
    status_d = status_q;
    err_d = err_q;
    status_d[ST_ACTIVE] = bus_activity;
    if (bus_activity) status_d[ST_IDLE] = 1'b0;
    if (synch_break) status_d[ST_ABORT] = busy_q;
    if (synch_break) status_d[ST_IDREQ] = 1'b0;
    if (clr_irq) status_d[ST_IRQ] = 1'b0;
    if (clr_err) begin
      status_d[ST_ERROR] = 1'b0;
      err_d = 8'h00;
    end
    if (tx_start || start_go) status_d[ST_DONE] = 1'b0;
    if (wake_go) status_d[ST_WAKE] = 1'b1;
    // sets below win over clears above
    if (id_received && !master_mode) begin
      status_d[ST_IDREQ] = 1'b1;
      status_d[ST_IRQ] = 1'b1;
    end
    if (tx_done && busy_q) begin
      status_d[ST_DONE] = 1'b1;
      status_d[ST_IRQ] = 1'b1;
    end
    if (idle_to) begin
      status_d[ST_IDLE] = 1'b1;
      status_d[ST_IRQ] = 1'b1;
    end
    if (wake_end && master_mode) begin
      status_d[ST_DONE] = 1'b1;
      status_d[ST_IRQ] = 1'b1;
    end
    if (resp_to && !bus_activity) begin
      status_d[ST_ERROR] = 1'b1;
      err_d[ER_WAKE_RESPONSE_TIMEOUT_FLAG] = 1'b1;
      status_d[ST_IRQ] = 1'b1;
    end
    if (wake_detect) begin
      status_d[ST_WAKE] = 1'b1;
      status_d[ST_DONE] = 1'b1;
      status_d[ST_IRQ] = 1'b1;
    end
    if (comm_error) begin
      status_d[ST_ERROR] = 1'b1;
      err_d = err_d | error_code;
      status_d[ST_IRQ] = 1'b1;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      status_q <= STATUS_RESET;
      err_q <= 8'h00;
      state_q <= S_IDLE;
      cnt_q <= 32'h0;
      busy_q <= 1'b0;
    end else begin
      status_q <= status_d;
      err_q <= err_d;
      state_q <= state_d;
      cnt_q <= cnt_d;
      busy_q <= busy_d;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      sleep_q <= 1'b0;
      mode_q <= 1'b0;
      ck_q <= 1'b0;
    end else begin
      if (wr_ctl) sleep_q <= reg_wdata[CT_SLEEP];
      mode_q <= master_mode;
      ck_q <= cksum_cfg;
    end
  end
endmodule // lin_sleep_wake_error_ctrl

// file: tb_lin_sleep_wake_error_ctrl.sv
/* testbench for the sleep, wake and error block.
   inputs change at falling edges; far node answers wake-ups only after t_suspend sets answer. */
`timescale 1ns/100ps
module tb_lin_sleep_wake_error_ctrl import lin_sleep_pkg::*;;
  logic clk = 1'b0, resetn = 1'b0, reg_wr = 1'b0, master_mode = 1'b1;
  logic cksum_cfg = 1'b0, wake_detect = 1'b0, tx_start = 1'b0;
  logic tx_done = 1'b0, synch_break = 1'b0, id_received = 1'b0;
  logic comm_error = 1'b0, answer = 1'b0, ping = 1'b0, wq, sq;
  logic [7:0] reg_idx = 8'h00, reg_wdata = 8'h00, error_code = 8'h00;
  logic [7:0] reg_rdata;
  logic bus_activity, wake_tx_done, wake_tx_req, frame_start;
  logic frame_abort, iface_reset, sleep_out, irq;
  int bad_count = 0, compares = 0;
  always #50 clk = ~clk;
  lin_sleep_wake_error_ctrl #(.IDLE_CNT(300), .WAKE_CNT(10))
    lin_sleep_wake_error_ctrl_inst (.*);
  lin_far_node lin_far_node_inst (.*);
  task automatic chk(input string nm, input logic [7:0] e, g);
    compares++;
    if (g !== e) begin
      bad_count++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic rd(input logic [7:0] i, m, e, input string nm);
    @(negedge clk) reg_idx = i;
    #1 chk(nm, e, reg_rdata & m);
  endtask
  task automatic wr(input logic [7:0] i, d);
    @(negedge clk) reg_wr = 1'b1;
    reg_idx = i;
    reg_wdata = d;
    #1 wq = wake_tx_req;
    sq = frame_start;
    @(negedge clk) reg_wr = 1'b0;
  endtask
  task automatic pl(ref logic s);
    @(negedge clk) s = 1'b1;
    @(negedge clk) s = 1'b0;
  endtask
  task automatic close_out;
    $display("mismatches %0d compares %0d", bad_count, compares);
    if (bad_count == 0 && compares > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic t_wake;
    wr(STATUS_IDX, 8'hff);
    rd(STATUS_IDX, 8'hff, STATUS_RESET, "status");
    wr(CONTROL_IDX, 8'h02);
    chk("wake req", 1'b1, wq);
    repeat (8) @(negedge clk);
    rd(STATUS_IDX, 8'h0b, 8'h0b, "master wake");
    wr(CONTROL_IDX, 8'h08);
    rd(STATUS_IDX, 8'h08, 8'h00, "irq clear");
    master_mode = 1'b0;
    wr(CONTROL_IDX, 8'h02);
    repeat (7) @(negedge clk);
    rd(STATUS_IDX, 8'h08, 8'h00, "slave sent");
    repeat (15) @(negedge clk);
    rd(STATUS_IDX, 8'h0c, 8'h0c, "slave timeout");
    rd(ERROR_IDX, 8'h04, 8'h04, "timeout flag");
    wr(CONTROL_IDX, 8'h02);
    chk("wake refused", 1'b0, wq);
    wr(CONTROL_IDX, 8'h0c);
    rd(ERROR_IDX, 8'hff, 8'h00, "error clear");
    rd(STATUS_IDX, 8'h0c, 8'h00, "status clear");
  endtask
  task automatic t_idle;
    pl(ping);
    rd(STATUS_IDX, 8'hc0, 8'h80, "active");
    repeat (305) @(negedge clk);
    rd(STATUS_IDX, 8'h48, 8'h48, "idle timeout");
    chk("irq", 1'b1, irq);
    wr(CONTROL_IDX, 8'h48);
    pl(wake_detect);
    rd(STATUS_IDX, 8'h0b, 8'h0b, "wake seen");
    wr(CONTROL_IDX, 8'h08);
    chk("sleep", 1'b0, sleep_out);
  endtask
  task automatic t_error;
    master_mode = 1'b1;
    pl(tx_start);
    rd(STATUS_IDX, 8'h01, 8'h00, "done cleared");
    @(negedge clk) comm_error = 1'b1;
    error_code = 8'h11;
    #1 chk("abort", 1'b1, frame_abort);
    rd(ERROR_IDX, 8'hff, 8'h11, "error code");
    comm_error = 1'b0;
    wr(CONTROL_IDX, 8'h01);
    chk("start refused", 1'b0, sq);
    wr(CONTROL_IDX, 8'h0c);
    wr(CONTROL_IDX, 8'h01);
    chk("start taken", 1'b1, sq);
    pl(tx_start);
    @(negedge clk) cksum_cfg = 1'b1;
    #1 chk("cksum change", 1'b1, iface_reset);
    pl(tx_start);
    @(negedge clk) master_mode = 1'b0;
    #1 chk("mode change", 1'b1, iface_reset);
  endtask
  task automatic t_suspend;
    master_mode = 1'b0;
    answer = 1'b1;
    wr(CONTROL_IDX, 8'h10);
    wr(CONTROL_IDX, 8'h02);
    chk("suspend refuse", 1'b0, wq);
    pl(synch_break);
    wr(CONTROL_IDX, 8'h02);
    chk("resume wake", 1'b1, wq);
    repeat (20) @(negedge clk);
    rd(STATUS_IDX, 8'h04, 8'h00, "answered wake");
  endtask
  initial begin
    repeat (16) @(negedge clk);
    resetn = 1'b1;
    t_wake;
    t_idle;
    t_error;
    t_suspend;
    close_out;
  end
  initial begin
    repeat (3000) @(negedge clk);
    bad_count++;
    close_out;
  end
endmodule // tb_lin_sleep_wake_error_ctrl
bind lin_sleep_wake_error_ctrl lin_ctrl_properties lin_ctrl_properties_inst (.*);
